// *** cpu_clear_call_decrement_ops.sv ***
// Purpose: executes watchdog clear, call via accumulator, complement, clear and decrement ops
// Assumes: instruction at pc offered with instr_valid; file read data combinational on file_raddr
// Notes: file writes leave one cycle late from flip-flops and are bypassed to the next operand
//
// Operation
// RL1: watchdog clear loads watchdog counter with zero
// RL2: watchdog clear also resets watchdog prescaler
// RL3: watchdog clear sets timeout and powerdown flags
// RL4: call pushes pc plus one onto stack
// RL5: call loads pc from latch and accumulator
// RL6: call takes two instruction cycles
// RL7: complement writes inverted file, updates zero flag
// RL8: destination bit zero accumulator, one file
// RL9: clear file writes zero, sets zero flag
// RL10: decrement file writes minus one, updates zero
// RL11: clear accumulator writes zero, sets zero flag
// RL12: decrement skip writes minus one, flags untouched
// RL13: zero result discards next instruction as nop
// RL14: nonzero result runs next instruction normally
// RL15: zero flag set exactly when result zero
// RL16: other ops in group take one cycle
`default_nettype none

module cpu_clear_call_decrement_ops (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpu_ops_pkg::axi_addr_w-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cpu_ops_pkg::axi_addr_w-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic instr_valid,
  input wire cpu_ops_pkg::instr_t instr,
  output logic instr_ready,
  output logic [cpu_ops_pkg::pc_w-1:0] pc,
  output logic [cpu_ops_pkg::faddr_w-1:0] file_raddr,
  input wire logic [cpu_ops_pkg::data_w-1:0] file_rdata,
  output cpu_ops_pkg::file_write_t file_write,
  output logic push_valid,
  output logic [cpu_ops_pkg::pc_w-1:0] push_addr,
  output logic watchdog_counter_clear,
  output logic watchdog_prescaler_clear,
  input wire logic timeout_event,
  input wire logic sleep_event,
  output logic unsupported_op
);
  import cpu_ops_pkg::*;

  exec_state_t state;
  exec_state_t next_state;
  logic [data_w-1:0] accumulator;
  logic [latch_w-1:0] pc_high_latch;
  logic zero_flag;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  logic [31:0] retired;
  logic reg_wr;
  logic [axi_addr_w-1:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic [axi_addr_w-1:0] reg_raddr;
  logic [31:0] reg_rdata;
  alu_out_t alu_out;

  // ==========================================================================
  // register bus
  cpu_ops_axi_slave bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata)
  );

  wire logic bus_wr_accumulator = reg_wr && (reg_waddr == reg_accumulator) && reg_wstrb[0];
  wire logic bus_wr_pc_high_latch = reg_wr && (reg_waddr == reg_pc_high_latch) && reg_wstrb[0];

  wire logic [31:0] status_word =
    32'(zero_flag) << status_zero_bit |
    32'(powerdown_flag_n) << status_powerdown_bit |
    32'(timeout_flag_n) << status_timeout_bit;

  wire logic [31:0] accumulator_word = {24'h0, accumulator};
  wire logic [31:0] pc_high_latch_word = {25'h0, pc_high_latch};
  wire logic [31:0] pc_word = {17'h0, pc};

  assign reg_rdata =
    (reg_raddr == reg_accumulator) ? accumulator_word :
    (reg_raddr == reg_pc_high_latch) ? pc_high_latch_word :
    (reg_raddr == reg_status) ? status_word :
    (reg_raddr == reg_program_counter) ? pc_word :
    (reg_raddr == reg_retired) ? retired : 32'h0000_0000;

  // ==========================================================================
  // decode
  wire logic [7:0] minor = {instr.dest, instr.faddr};
  wire logic is_misc = (instr.major == major_misc);
  wire logic is_watchdog_clear = is_misc && (minor == minor_watchdog_clear);
  wire logic is_call = is_misc && (minor == minor_call_via_accumulator);
  wire logic is_clear = (instr.major == major_clear);
  wire logic is_decrement = (instr.major == major_decrement);
  wire logic is_complement = (instr.major == major_complement);
  wire logic is_decrement_skip = (instr.major == major_decrement_skip);
  wire logic is_known = is_watchdog_clear || is_call || is_clear || is_decrement || is_complement ||
    is_decrement_skip;

  // an instruction is taken only in the execute state; the call's second cycle holds ready low
  assign instr_ready = (state != st_call2); // see RL6
  wire logic take = (state == st_exec) && instr_valid;
  // a discarded instruction advances pc and changes nothing else
  wire logic discard = (state == st_skip) && instr_valid; // see RL13

  // ==========================================================================
  // operand fetch with bypass of the write still in flight
  assign file_raddr = instr.faddr;
  // the previous result still sits in the file_write register, one cycle ahead of the file
  wire logic bypass = file_write.valid && (file_write.addr == instr.faddr);
  wire logic [data_w-1:0] operand = bypass ? file_write.data : file_rdata;

  wire alu_fn_t fn = alu_fn_t'(
    is_clear ? alu_clear : // see RL9 RL11
    is_complement ? alu_complement : // see RL7
    (is_decrement || is_decrement_skip) ? alu_decrement : alu_pass); // see RL10 RL12

  cpu_op_alu alu (
    .fn(fn),
    .operand(operand),
    .out(alu_out)
  );

  wire logic writes_result = take && (is_clear || is_complement || is_decrement || is_decrement_skip);
  wire logic to_file = writes_result && (instr.dest != dest_accumulator); // see RL8
  wire logic to_accumulator = writes_result && (instr.dest == dest_accumulator); // see RL8
  // the skip variant leaves every flag alone
  wire logic updates_zero = take && (is_clear || is_complement || is_decrement); // see RL12 RL15
  wire logic skip_taken = take && is_decrement_skip && alu_out.zero; // see RL13 RL14

  // ==========================================================================
  // sequencing
  wire logic [pc_w-1:0] pc_plus_one = pc + 15'h0001;
  // latch and accumulator are read at the second cycle's edge, so a bus write in between counts
  wire logic [pc_w-1:0] call_target = {pc_high_latch, accumulator}; // see RL5

  always_comb begin
    next_state = state;
    unique case (state)
      st_exec: begin
        if (take && is_call) begin
          next_state = st_call2; // see RL6
        end else if (skip_taken) begin
          next_state = st_skip; // see RL13
        end
      end
      st_call2: begin
        next_state = st_exec;
      end
      st_skip: begin
        if (discard) begin
          next_state = st_exec;
        end
      end
      default: begin
        next_state = st_exec;
      end
    endcase
  end

  wire logic [pc_w-1:0] next_pc =
    (state == st_call2) ? call_target : // see RL5
    ((take && !is_call) || discard) ? pc_plus_one : pc; // see RL14 RL16

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_exec;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= pc_reset;
    end else begin
      pc <= next_pc;
    end
  end

  // ==========================================================================
  // architectural state
  wire logic [data_w-1:0] next_accumulator =
    to_accumulator ? alu_out.result : // see RL11
    bus_wr_accumulator ? reg_wdata[data_w-1:0] : accumulator;
  wire logic next_zero = updates_zero ? alu_out.zero : zero_flag; // see RL9 RL11 RL15

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accumulator <= accumulator_reset;
      zero_flag <= 1'b0;
    end else begin
      accumulator <= next_accumulator;
      zero_flag <= next_zero;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_high_latch <= pc_high_latch_reset;
    end else if (bus_wr_pc_high_latch) begin
      pc_high_latch <= reg_wdata[latch_w-1:0];
    end
  end

  // the watchdog clear wins over a timeout or sleep event in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag_n <= 1'b1;
    end else if (take && is_watchdog_clear) begin
      timeout_flag_n <= 1'b1; // see RL3
    end else if (timeout_event) begin
      timeout_flag_n <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_flag_n <= 1'b1;
    end else if (take && is_watchdog_clear) begin
      powerdown_flag_n <= 1'b1; // see RL3
    end else if (sleep_event) begin
      powerdown_flag_n <= 1'b0;
    end
  end

  // ==========================================================================
  // registered side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_write <= '0;
    end else begin
      file_write.valid <= to_file; // see RL7 RL9 RL10 RL12
      file_write.addr <= instr.faddr;
      file_write.data <= alu_out.result;
    end
  end

  // one-cycle pulses to the stack, the watchdog and the fault monitor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_valid <= 1'b0;
      push_addr <= pc_reset;
      watchdog_counter_clear <= 1'b0;
      watchdog_prescaler_clear <= 1'b0;
      unsupported_op <= 1'b0;
    end else begin
      push_valid <= take && is_call; // see RL4
      push_addr <= pc_plus_one; // see RL4
      watchdog_counter_clear <= take && is_watchdog_clear; // see RL1
      watchdog_prescaler_clear <= take && is_watchdog_clear; // see RL2
      unsupported_op <= take && !is_known;
    end
  end

  // retired counts completed instructions, a discarded one not included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retired <= 32'h0000_0000;
    end else if (take) begin
      retired <= retired + 32'h0000_0001;
    end
  end

endmodule // cpu_clear_call_decrement_ops

`default_nettype wire

// *** cpu_ops_pkg.sv ***
// Purpose: shared types and constants for the clear/call/decrement instruction group
// Assumes: 14-bit instruction word, 7-bit file address, 15-bit program counter
// Notes: opcode encodings are local constants of this code base
`default_nettype none

package cpu_ops_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned pc_w = 15;
  localparam int unsigned data_w = 8;
  localparam int unsigned faddr_w = 7;
  localparam int unsigned latch_w = 7;
  localparam int unsigned axi_addr_w = 8;

  // ==========================================================================
  // instruction word and opcodes
  typedef struct packed {
    logic [5:0] major;
    logic dest;
    logic [faddr_w-1:0] faddr;
  } instr_t;

  localparam logic [5:0] major_misc = 6'h00;
  localparam logic [5:0] major_clear = 6'h01;
  localparam logic [5:0] major_decrement = 6'h03;
  localparam logic [5:0] major_complement = 6'h09;
  localparam logic [5:0] major_decrement_skip = 6'h0b;
  localparam logic [7:0] minor_watchdog_clear = 8'h64;
  localparam logic [7:0] minor_call_via_accumulator = 8'h0a;
  localparam logic dest_accumulator = 1'b0;

  // ==========================================================================
  // datapath carriers
  typedef struct packed {
    logic valid;
    logic [faddr_w-1:0] addr;
    logic [data_w-1:0] data;
  } file_write_t;

  typedef struct packed {
    logic [data_w-1:0] result;
    logic zero;
  } alu_out_t;

  typedef enum logic [1:0] {
    alu_pass = 2'h0,
    alu_complement = 2'h1,
    alu_decrement = 2'h2,
    alu_clear = 2'h3
  } alu_fn_t;

  typedef enum logic [2:0] {
    st_exec = 3'b001,
    st_call2 = 3'b010,
    st_skip = 3'b100
  } exec_state_t;

  // ==========================================================================
  // register map, fields and reset values
  localparam logic [axi_addr_w-1:0] reg_accumulator = 8'h00;
  localparam logic [axi_addr_w-1:0] reg_pc_high_latch = 8'h04;
  localparam logic [axi_addr_w-1:0] reg_status = 8'h08;
  localparam logic [axi_addr_w-1:0] reg_program_counter = 8'h0c;
  localparam logic [axi_addr_w-1:0] reg_retired = 8'h10;
  localparam int unsigned status_zero_bit = 0;
  localparam int unsigned status_powerdown_bit = 3;
  localparam int unsigned status_timeout_bit = 4;
  localparam logic [data_w-1:0] accumulator_reset = 8'h00;
  localparam logic [latch_w-1:0] pc_high_latch_reset = 7'h00;
  localparam logic [pc_w-1:0] pc_reset = 15'h0000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  function automatic logic reg_mapped(input logic [axi_addr_w-1:0] a);
    return (a == reg_accumulator) || (a == reg_pc_high_latch) || (a == reg_status) ||
           (a == reg_program_counter) || (a == reg_retired);
  endfunction

endpackage

`default_nettype wire

// *** cpu_op_alu.sv ***
// Purpose: result and zero flag for complement, decrement, clear and pass
// Assumes: purely combinational, 8-bit operand
// Notes: zero is computed for every function, the caller decides whether to keep it
`default_nettype none

module cpu_op_alu (
  input wire cpu_ops_pkg::alu_fn_t fn,
  input wire logic [cpu_ops_pkg::data_w-1:0] operand,
  output cpu_ops_pkg::alu_out_t out
);
  import cpu_ops_pkg::*;

  // ==========================================================================
  // function select
  wire logic [data_w-1:0] dec_value = operand - 8'h01;
  wire logic [data_w-1:0] result =
    (fn == alu_complement) ? ~operand :
    (fn == alu_decrement) ? dec_value :
    (fn == alu_clear) ? 8'h00 : operand;

  assign out = {result, (result == 8'h00)}; // see RL15

endmodule // cpu_op_alu

`default_nettype wire

// *** cpu_ops_axi_slave.sv ***
// Purpose: axi4-lite slave front end with one write and one read in flight
// Assumes: single clock, synchronous active-low reset
// Notes: write address and data taken in either order; unmapped gives slverr
`default_nettype none

module cpu_ops_axi_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpu_ops_pkg::axi_addr_w-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cpu_ops_pkg::axi_addr_w-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic reg_wr,
  output logic [cpu_ops_pkg::axi_addr_w-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  output logic [cpu_ops_pkg::axi_addr_w-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata
);
  import cpu_ops_pkg::*;

  logic aw_held;
  logic w_held;
  logic [axi_addr_w-1:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  // ==========================================================================
  // handshakes
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  wire logic have_aw = aw_held || (awvalid && awready);
  wire logic have_w = w_held || (wvalid && wready);
  wire logic fire = have_aw && have_w && !bvalid;
  assign reg_waddr = aw_held ? aw_q : awaddr;
  assign reg_wdata = w_held ? w_q : wdata;
  assign reg_wstrb = w_held ? s_q : wstrb;
  assign reg_wr = fire && reg_mapped(reg_waddr);
  assign reg_raddr = araddr;

  // ==========================================================================
  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      s_q <= '0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else begin
      if (awvalid && awready && !fire) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready && !fire) begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
      if (fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_mapped(reg_waddr) ? resp_okay : resp_slverr;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= resp_okay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= reg_mapped(araddr) ? reg_rdata : 32'h0000_0000;
      rresp <= reg_mapped(araddr) ? resp_okay : resp_slverr;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // cpu_ops_axi_slave

`default_nettype wire

// *** cpu_ops_checker_sva.sv ***
// Purpose: port-level checks of the clear, call and decrement instruction group
// Assumes: one clock, synchronous active-low reset, no same-address write bypass
// Notes: bound to the top module at the foot of this file
`default_nettype none

module cpu_ops_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire cpu_ops_pkg::instr_t instr,
  input wire logic instr_ready,
  input wire logic [cpu_ops_pkg::pc_w-1:0] pc,
  input wire logic [cpu_ops_pkg::data_w-1:0] file_rdata,
  input wire cpu_ops_pkg::file_write_t file_write,
  input wire logic push_valid,
  input wire logic [cpu_ops_pkg::pc_w-1:0] push_addr,
  input wire logic watchdog_counter_clear,
  input wire logic watchdog_prescaler_clear
);
  import cpu_ops_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // helper: an instruction taken while a skip is pending is discarded
  logic skip_q;
  wire logic take = instr_valid && instr_ready;
  wire logic vop = take && !skip_q;
  wire logic [13:0] iw = instr;
  wire logic is_call = iw == {major_misc, minor_call_via_accumulator};
  wire logic is_dec = instr.major == major_decrement || instr.major == major_decrement_skip;
  wire logic is_group = instr.major == major_complement || is_dec || instr.major == major_clear;

  always_ff @(posedge aclk) begin
    if (!aresetn) skip_q <= 1'b0;
    else if (take) skip_q <= vop && instr.major == major_decrement_skip && file_rdata == 8'h01;
  end

  sequence call_taken;
    vop && is_call;
  endsequence

  sequence stall_then_ready;
    !instr_ready ##1 instr_ready;
  endsequence

  // ==========================================================================
  // assertions
  AST_WDOG_CLEAR: assert property (vop && iw == {major_misc, minor_watchdog_clear} |=> watchdog_counter_clear)
    else $error("watchdog clear pulse missing");
  AST_WDOG_PAIR: assert property (watchdog_counter_clear == watchdog_prescaler_clear)
    else $error("counter and prescaler clears differ");
  AST_CALL_PUSH: assert property (call_taken |=> push_valid && push_addr == $past(pc) + 15'h1)
    else $error("call push wrong");
  AST_CALL_STALL: assert property (call_taken |=> stall_then_ready)
    else $error("call not two cycles");
  AST_PUSH_PULSE: assert property (push_valid |=> !push_valid)
    else $error("push longer than one cycle");
  AST_PC_STEP: assert property (take && !(vop && is_call) |=> pc == $past(pc) + 15'h1)
    else $error("pc did not advance by one");
  AST_COMPLEMENT_FILE: assert property (vop && instr.major == major_complement && instr.dest |=>
    file_write == {1'b1, $past(instr.faddr), ~$past(file_rdata)})
    else $error("complement file write wrong");
  AST_CLEAR_FILE: assert property (vop && instr.major == major_clear && instr.dest |=>
    file_write == {1'b1, $past(instr.faddr), 8'h00})
    else $error("clear file write wrong");
  AST_DEC_FILE: assert property (vop && is_dec && instr.dest |=>
    file_write.valid && file_write.data == $past(file_rdata) - 8'h01)
    else $error("decrement file write wrong");
  AST_ACC_DEST: assert property (vop && is_group && !instr.dest |=> !file_write.valid)
    else $error("file written for accumulator destination");
endmodule // cpu_ops_checker

bind cpu_clear_call_decrement_ops cpu_ops_checker u_chk (.aclk, .aresetn, .instr_valid, .instr, .instr_ready, .pc,
  .file_rdata, .file_write, .push_valid, .push_addr, .watchdog_counter_clear, .watchdog_prescaler_clear);

`default_nettype wire

// *** cpu_clear_call_decrement_ops_tb_top.sv ***
// Purpose: self-checking bench for the clear, call and decrement instruction group
// Assumes: one idle cycle between instructions, so no write bypass is exercised
// Notes: registers reached over axi4-lite tasks
`default_nettype none

module cpu_clear_call_decrement_ops_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_ops_pkg::*;

  // ==========================================================================
  // signals
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic instr_valid = 1'b0, timeout_event = 1'b0, sleep_event = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, file_rdata = 8'h00, acc_m;
  logic [31:0] wdata = 32'h0, rdata, rd, st0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, instr_ready, push_valid;
  logic watchdog_counter_clear, watchdog_prescaler_clear, unsupported_op;
  instr_t instr = '0;
  logic [14:0] pc, push_addr, p0;
  logic [6:0] file_raddr;
  file_write_t file_write;
  int fail_count = 0, n_checks = 0;

  cpu_clear_call_decrement_ops DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .instr_valid, .instr,
    .instr_ready, .pc, .file_raddr, .file_rdata, .file_write, .push_valid, .push_addr, .watchdog_counter_clear,
    .watchdog_prescaler_clear, .timeout_event, .sleep_event, .unsupported_op);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // presents one instruction, returns just after the edge that takes it
  task automatic op(input logic [5:0] mj, input logic [7:0] lo, input logic [7:0] fd);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr <= {mj, lo};
    file_rdata <= fd;
    @(posedge aclk);
    instr_valid <= 1'b0;
    file_rdata <= ~fd;
    #1;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    axr(reg_status, rd, rs);
    chk(rd, 32'h18);
    axr(reg_accumulator, rd, rs);
    chk(rd, {24'h0, accumulator_reset});
    chk(pc, pc_reset);
  endtask

  task automatic t_file;
    logic [29:0] tc [6] = '{{major_complement, 8'hff, 8'hff, 8'h00}, {major_complement, 8'h05, 8'h5a, 8'ha5},
      {major_decrement, 8'h81, 8'h01, 8'h00}, {major_decrement, 8'h02, 8'h00, 8'hff},
      {major_clear, 8'h80, 8'h33, 8'h00}, {major_clear, 8'h15, 8'h00, 8'h00}};
    acc_m = 8'h00;
    for (int i = 0; i < 6; i++) begin
      p0 = pc;
      op(tc[i][29:24], tc[i][23:16], tc[i][15:8]);
      chk(pc, p0 + 15'h1);
      chk(file_raddr, tc[i][22:16]);
      if (tc[i][23]) begin
        chk(file_write, {1'b1, tc[i][22:16], tc[i][7:0]});
      end else begin
        chk(file_write.valid, 1'b0);
        acc_m = tc[i][7:0];
      end
      axr(reg_accumulator, rd, rs);
      chk(rd, acc_m);
      axr(reg_status, rd, rs);
      chk(rd[0], tc[i][7:0] == 8'h00);
    end
  endtask

  task automatic t_skip;
    op(major_decrement_skip, 8'h90, 8'h02);
    chk(file_write, {1'b1, 7'h10, 8'h01});
    axr(reg_status, rd, rs);
    chk(rd[0], 1'b1);
    op(major_decrement, 8'h00, 8'h10);
    axr(reg_accumulator, rd, rs);
    chk(rd, 32'h0f);
    p0 = pc;
    op(major_decrement_skip, 8'h00, 8'h01);
    op(major_complement, 8'h00, 8'h00);
    chk(pc, p0 + 15'h2);
    axr(reg_accumulator, rd, rs);
    chk(rd, 32'h00);
    axr(reg_status, rd, rs);
    chk(rd[0], 1'b0);
  endtask

  task automatic t_wdog;
    @(posedge aclk);
    timeout_event <= 1'b1;
    sleep_event <= 1'b1;
    @(posedge aclk);
    timeout_event <= 1'b0;
    sleep_event <= 1'b0;
    axr(reg_status, rd, rs);
    chk(rd & 32'h18, 32'h00);
    op(major_misc, minor_watchdog_clear, 8'h00);
    chk(watchdog_counter_clear, 1'b1);
    chk(watchdog_prescaler_clear, 1'b1);
    axr(reg_status, rd, rs);
    chk(rd & 32'h18, 32'h18);
  endtask

  task automatic t_call;
    axw(reg_pc_high_latch, 32'h2b, rs);
    axw(reg_accumulator, 32'hc4, rs);
    axr(reg_status, st0, rs);
    p0 = pc;
    op(major_misc, minor_call_via_accumulator, 8'h00);
    chk(push_valid, 1'b1);
    chk(push_addr, p0 + 15'h1);
    chk(instr_ready, 1'b0);
    chk(pc, p0);
    @(posedge aclk);
    #1;
    chk(pc, {7'h2b, 8'hc4});
    chk(instr_ready, 1'b1);
    axr(reg_status, rd, rs);
    chk(rd, st0);
  endtask

  task automatic t_bus;
    p0 = pc;
    op(6'h3f, 8'h00, 8'h00);
    chk(unsupported_op, 1'b1);
    chk(pc, p0 + 15'h1);
    axr(reg_retired, rd, rs);
    chk(rd, 32'h0000_000c);
    axr(reg_program_counter, rd, rs);
    chk(rd, 32'(p0) + 32'h1);
    axr(8'h14, rd, rs);
    chk(rs, resp_slverr);
    chk(rd, 32'h0);
    axw(8'h20, 32'h1, rs);
    chk(rs, resp_slverr);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_file;
    t_skip;
    t_wdog;
    t_call;
    t_bus;
    print_verdict();
  end

  initial begin
    #40000;
    fail_count++;
    print_verdict();
  end
endmodule // cpu_clear_call_decrement_ops_tb_top

`default_nettype wire
